// >>> logic/line_feed_pkg.sv
// constants, field layouts and carrier types for the line feed control registers
// assumes a single 250 MHz clock and the plain register port described in the top module
//
// Functional notes
// [RULE_01] converter variant: feed bit 4 picks overhead span, 0 is 9 V, 1 is 13.5 V
// [RULE_02] converter variant: feed bit 3 forces battery to high setting; else reads 0
// [RULE_03] feed bit 2 reads 0 on converter variant, 1 on external-battery variants
// [RULE_04] external-battery variants: feed bit 1 picks battery and drives switch output
// [RULE_05] converter variant: feed bit 0 picks tracking, 1 follows ring voltage
// [RULE_06] control bit 6 forces tip or ring to follow common-mode setting
// [RULE_07] control bit 5 forces differential voltage to follow on-hook setting
// [RULE_08] control bit 4 enables automatic speed-up
// [RULE_09] control bit 3 switches to low battery automatically while off-hook
// [RULE_10] control bit 2 moves line to active on debounced ring trip
// [RULE_11] control bit 1 moves line to active on debounced loop closure
// [RULE_12] control bit 0 moves line to open on power alarm
// [RULE_13] status bit 2 is raw detector output, active low
// [RULE_14] status bit 1 is debounced ring-trip indicator, read only
// [RULE_15] status bit 0 is debounced loop-closure indicator, read only
// [RULE_16] open state is code 000, active is 001 forward or 101 reverse
// [RULE_17] indicators assert after raw input steady for 0 to 159 ms in 1.25 ms steps
// [RULE_18] status writes ignored, reserved bits always return fixed values; converter feed bit 1 resets to 1, reads 0 after a write
`default_nettype none
package line_feed_pkg;

  localparam logic [7:0] feed_offset    = 8'h42;
  localparam logic [7:0] control_offset = 8'h43;
  localparam logic [7:0] status_offset  = 8'h44;
  localparam logic [7:0] irq_stat_offset = 8'h45;
  localparam logic [7:0] irq_mask_offset = 8'h46;
  localparam logic [7:0] lc_interval_offset = 8'h47;
  localparam logic [7:0] rt_interval_offset = 8'h48;

  localparam int overhead_bit  = 4;
  localparam int force_bit     = 3;
  localparam int fixed_bit     = 2;
  localparam int supply_bit    = 1;
  localparam int track_bit     = 0;

  localparam logic [7:0] feed_reset_conv = 8'h03;
  localparam logic [7:0] feed_reset_ext  = 8'h06;
  localparam logic [7:0] feed_mask_conv  = 8'h19;
  localparam logic [7:0] feed_mask_ext   = 8'h02;
  localparam logic [7:0] control_mask    = 8'h7f;
  localparam logic [7:0] control_reset   = 8'h00;
  localparam logic [6:0] interval_reset  = 7'h0a;

  localparam logic [2:0] state_open       = 3'h0;
  localparam logic [2:0] state_fwd_active = 3'h1;
  localparam logic [2:0] state_rev_active = 3'h5;

  // the 1.25 ms step of the debounce interval, as cycles of the 4 ns clock
  localparam int step_ns     = 1250000;
  localparam int clk_ns      = 4;
  localparam int step_cycles = step_ns / clk_ns;

  typedef struct packed {
    logic       common_mode_manual;
    logic       differential_manual;
    logic       speedup_enable;
    logic       auto_battery_switch;
    logic       auto_active_on_ring_trip;
    logic       auto_active_on_loop_closure;
    logic       auto_open_on_power_alarm;
  } control_s;

  typedef struct packed {
    logic       overhead_range_sel;
    logic       battery_force_high_follow;
    logic       battery_supply_select;
    logic       track_ring;
  } feed_s;

endpackage : line_feed_pkg
`default_nettype wire

// >>> logic/steady_filter.sv
// debounce filter: output follows the input once it has stood still for the interval
// assumes a one-cycle step tick from the caller
`timescale 1ns/1ps
`default_nettype none
module steady_filter (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       step_tick,
  input  wire logic       raw_in,
  input  wire logic [6:0] interval,
  output logic            filtered
);

  logic       last_raw;
  logic [6:0] steps;
  wire        moved   = raw_in != last_raw;
  wire        elapsed = steps >= interval;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_raw <= 1'b0;
      steps    <= 7'h00;
      filtered <= 1'b0;
    end else begin
      last_raw <= raw_in;
      if (moved) begin
        steps <= 7'h00;
      end else if (step_tick && !elapsed) begin
        steps <= steps + 7'h01;
      end
      if (!moved && elapsed) begin
        filtered <= raw_in; // see [RULE_17]
      end
    end
  end

  // a change of the filtered value needs the raw level steady over the whole count
  a_filter_steady : assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(filtered) |-> $past(raw_in) == filtered && $past(elapsed)) // see [RULE_17]
    else $error("filter changed before the interval elapsed");

endmodule : steady_filter
`default_nettype wire

// >>> logic/line_feed_regs.sv
// line feed battery and automatic control registers with detection status
// assumes synchronous detector inputs and a one-cycle read/write strobe master
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module line_feed_regs #(
  parameter bit       converter_variant = 1'b1,
  parameter int       step_count        = line_feed_pkg::step_cycles
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic [7:0]      rdata,
  input  wire logic       ring_trip_raw_n,
  input  wire logic       loop_closure_raw_n,
  input  wire logic       power_alarm,
  input  wire logic       reverse_polarity,
  input  wire logic [2:0] line_state_request,
  input  wire logic       off_hook,
  output logic [2:0]      actual_line_state,
  output logic            battery_switch_out,
  output line_feed_pkg::feed_s    feed_cfg,
  output line_feed_pkg::control_s control_cfg,
  output logic            use_low_battery,
  output logic            irq
);

  // ******************************************************
  // register storage
  // ******************************************************
  logic [7:0] feed;
  logic [6:0] control;
  logic [6:0] lc_interval;
  logic [6:0] rt_interval;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] last_state_request;
  logic       ring_trip_flag;
  logic       loop_closed_flag;
  logic       last_rt;
  logic       last_lc;
  logic       last_alarm;
  logic [31:0] step_div;
  logic       step_tick;

  localparam logic [7:0] feed_rw_mask =
    converter_variant ? line_feed_pkg::feed_mask_conv : line_feed_pkg::feed_mask_ext;
  localparam logic [7:0] feed_fixed =
    converter_variant ? 8'h00 : 8'h04;                   // see [RULE_03]

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction : hit

  wire wr_feed    = wr_en && hit(addr, line_feed_pkg::feed_offset);
  wire wr_control = wr_en && hit(addr, line_feed_pkg::control_offset);
  wire wr_istat   = wr_en && hit(addr, line_feed_pkg::irq_stat_offset);
  wire wr_imask   = wr_en && hit(addr, line_feed_pkg::irq_mask_offset);
  wire wr_lc      = wr_en && hit(addr, line_feed_pkg::lc_interval_offset);
  wire wr_rt      = wr_en && hit(addr, line_feed_pkg::rt_interval_offset);

  // reserved bits are masked off and the fixed bit forced, whatever is written
  wire [7:0] next_feed = (wdata & feed_rw_mask) | feed_fixed;   // see [RULE_18]

  // ******************************************************
  // debounce step divider and filters
  // ******************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_div  <= 32'h0;
      step_tick <= 1'b0;
    end else begin
      step_tick <= step_div == 32'(step_count - 1);
      step_div  <= (step_div == 32'(step_count - 1)) ? 32'h0 : step_div + 32'h1;
    end
  end

  logic rt_filtered;
  logic lc_filtered;

  steady_filter rt_filter (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .step_tick (step_tick),
    .raw_in    (!ring_trip_raw_n),
    .interval  (rt_interval),
    .filtered  (rt_filtered)
  );

  steady_filter lc_filter (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .step_tick (step_tick),
    .raw_in    (!loop_closure_raw_n),
    .interval  (lc_interval),
    .filtered  (lc_filtered)
  );

  // ******************************************************
  // automatic line state
  // ******************************************************
  wire [2:0] active_code = reverse_polarity ? line_feed_pkg::state_rev_active
                                            : line_feed_pkg::state_fwd_active;
  wire rt_rise    = ring_trip_flag && !last_rt;
  wire lc_rise    = loop_closed_flag && !last_lc;
  wire alarm_rise = power_alarm && !last_alarm;
  wire go_open    = control[0] && alarm_rise;                        // see [RULE_12]
  wire go_active  = (control[2] && rt_rise) || (control[1] && lc_rise); // see [RULE_10] [RULE_11]
  wire req_moved  = line_state_request != last_state_request;

  // enabled power alarm wins: its rise opens the line even in a cycle that would drive it active
  wire [2:0] next_state =
    go_open   ? line_feed_pkg::state_open :                          // see [RULE_16]
    go_active ? active_code :                                        // see [RULE_16]
    req_moved ? line_state_request : actual_line_state;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      actual_line_state  <= line_feed_pkg::state_open;
      last_state_request <= line_feed_pkg::state_open;
      last_rt            <= 1'b0;
      last_lc            <= 1'b0;
      last_alarm         <= 1'b0;
    end else begin
      actual_line_state  <= next_state;
      last_state_request <= line_state_request;
      last_rt            <= ring_trip_flag;
      last_lc            <= loop_closed_flag;
      last_alarm         <= power_alarm;
    end
  end

  // ******************************************************
  // registers, status and events
  // ******************************************************
  wire [2:0] events    = {alarm_rise, rt_rise, lc_rise};
  wire [2:0] next_istat = (irq_stat & ~(wr_istat ? wdata[2:0] : 3'h0)) | events;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      feed             <= converter_variant ? line_feed_pkg::feed_reset_conv
                                            : line_feed_pkg::feed_reset_ext;
      control          <= line_feed_pkg::control_reset[6:0];
      lc_interval      <= line_feed_pkg::interval_reset;
      rt_interval      <= line_feed_pkg::interval_reset;
      irq_stat         <= 3'h0;
      irq_mask         <= 3'h0;
      ring_trip_flag   <= 1'b0;
      loop_closed_flag <= 1'b0;
    end else begin
      if (wr_feed) begin
        feed <= next_feed;                                  // see [RULE_02] [RULE_04]
      end
      if (wr_control) begin
        control <= wdata[6:0] & line_feed_pkg::control_mask[6:0];
      end
      if (wr_lc) begin
        lc_interval <= wdata[6:0];
      end
      if (wr_rt) begin
        rt_interval <= wdata[6:0];
      end
      if (wr_imask) begin
        irq_mask <= wdata[2:0];
      end
      irq_stat         <= next_istat; // set wins over clear
      ring_trip_flag   <= rt_filtered;                      // see [RULE_14]
      loop_closed_flag <= lc_filtered;                      // see [RULE_15]
    end
  end

  // status register has no write path at all
  wire [7:0] status_word = {5'h00, ring_trip_raw_n & loop_closure_raw_n, // see [RULE_13]
                            ring_trip_flag, loop_closed_flag};           // see [RULE_18]

  wire [7:0] read_word =
    hit(addr, line_feed_pkg::feed_offset)        ? feed :
    hit(addr, line_feed_pkg::control_offset)     ? {1'b0, control} :
    hit(addr, line_feed_pkg::status_offset)      ? status_word :
    hit(addr, line_feed_pkg::irq_stat_offset)    ? {5'h00, irq_stat} :
    hit(addr, line_feed_pkg::irq_mask_offset)    ? {5'h00, irq_mask} :
    hit(addr, line_feed_pkg::lc_interval_offset) ? {1'b0, lc_interval} :
    hit(addr, line_feed_pkg::rt_interval_offset) ? {1'b0, rt_interval} : 8'h00;

  // ******************************************************
  // outputs, all registered
  // ******************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata              <= 8'h00;
      battery_switch_out <= 1'b0;
      feed_cfg           <= '0;
      control_cfg        <= '0;
      use_low_battery    <= 1'b0;
      irq                <= 1'b0;
    end else begin
      rdata              <= rd_en ? read_word : 8'h00;
      battery_switch_out <= !converter_variant && feed[line_feed_pkg::supply_bit]; // see [RULE_04]
      feed_cfg           <= {feed[line_feed_pkg::overhead_bit],        // see [RULE_01]
                             feed[line_feed_pkg::force_bit],           // see [RULE_02]
                             feed[line_feed_pkg::supply_bit],
                             feed[line_feed_pkg::track_bit]};          // see [RULE_05]
      control_cfg        <= control;                       // see [RULE_06] [RULE_07] [RULE_08]
      use_low_battery    <= control[3] && off_hook;        // see [RULE_09]
      irq                <= |(next_istat & irq_mask);
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  a_status_ro : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_18]
    wr_en && hit(addr, line_feed_pkg::status_offset) |=> $stable(ring_trip_flag) || rt_filtered)
    else $error("status write changed a flag");

  a_alarm_open : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_12]
    control[0] && alarm_rise |=> actual_line_state == line_feed_pkg::state_open)
    else $error("power alarm did not open line");

  a_rt_active : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_10]
    control[2] && rt_rise && !go_open |=> actual_line_state == $past(active_code))
    else $error("ring trip did not activate line");

  a_lc_active : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_11]
    control[1] && lc_rise && !go_open |=> actual_line_state == $past(active_code))
    else $error("loop closure did not activate line");

  a_feed_fixed : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_03]
    feed[line_feed_pkg::fixed_bit] == !converter_variant && feed[7:5] == 3'h0)
    else $error("fixed feed bits wrong");

  a_force_zero : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_02]
    !converter_variant |-> !feed[line_feed_pkg::force_bit])
    else $error("force bit set on external variant");

  a_switch_pin : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_04]
    wr_feed ##2 !wr_feed |-> battery_switch_out == (!converter_variant && $past(wdata[1], 2)))
    else $error("switch output does not follow select");

  a_raw_status : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_13]
    rd_en && hit(addr, line_feed_pkg::status_offset)
      |=> rdata[2] == $past(ring_trip_raw_n && loop_closure_raw_n))
    else $error("raw status bit wrong");

  a_low_battery : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_09]
    !control[3] |=> !use_low_battery)
    else $error("low battery used while disabled");

  a_read_once : assert property (@(posedge ref_clk) disable iff (sys_rst)
    !rd_en |=> rdata == 8'h00)
    else $error("read data outside read slot");

  a_ctrl_out : assert property (@(posedge ref_clk) disable iff (sys_rst) // see [RULE_06]
    wr_control ##1 !wr_control |=> control_cfg == $past(wdata[6:0], 2))
    else $error("control outputs do not follow register");

endmodule : line_feed_regs
`default_nettype wire

// >>> bench/line_model.sv
// subscriber line model: detector levels, power alarm and polarity
// assumes the bench asks for each line condition by a level request
`timescale 1ns/1ps
`default_nettype none
module line_model (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic want_loop,
  input  wire logic want_ring,
  input  wire logic want_alarm,
  input  wire logic want_rev,
  output logic      ring_trip_raw_n,
  output logic      loop_closure_raw_n,
  output logic      power_alarm,
  output logic      off_hook,
  output logic      reverse_polarity
);
  // ****************
  // line levels
  // ****************
  // detectors idle high: an open line never exceeds a threshold
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ring_trip_raw_n    <= 1'b1;
      loop_closure_raw_n <= 1'b1;
      power_alarm        <= 1'b0;
      off_hook           <= 1'b0;
      reverse_polarity   <= 1'b0;
    end else begin
      ring_trip_raw_n    <= ~want_ring;
      loop_closure_raw_n <= ~want_loop;
      power_alarm        <= want_alarm;
      off_hook           <= want_loop | want_ring;
      reverse_polarity   <= want_rev;
    end
  end
endmodule : line_model
`default_nettype wire

// >>> bench/test_line_feed_regs.sv
// self-checking bench for the line feed control registers
// assumes the line model beside it and a four-cycle debounce step
`timescale 1ns/1ps
`default_nettype none
module test_line_feed_regs;
  // ****************
  // signals
  // ****************
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [2:0] line_state_request = 3'h0;
  logic       want_loop = 1'b0, want_ring = 1'b0, want_alarm = 1'b0, want_rev = 1'b0;
  logic [7:0] rdata, rdata_x, rd_c, rd_x, w;
  logic       rt_n, lc_n, alarm, hook, rev, bsw, bsw_x, lowbat, irq;
  logic [2:0] state;
  line_feed_pkg::feed_s    feed_cfg;
  line_feed_pkg::control_s control_cfg;
  int         n_fail = 0, checks_done = 0, cycles = 0;

  always #2 ref_clk = ~ref_clk;

  line_model model (.ref_clk(ref_clk), .sys_rst(sys_rst), .want_loop(want_loop),
    .want_ring(want_ring), .want_alarm(want_alarm), .want_rev(want_rev),
    .ring_trip_raw_n(rt_n), .loop_closure_raw_n(lc_n), .power_alarm(alarm),
    .off_hook(hook), .reverse_polarity(rev));

  line_feed_regs #(.converter_variant(1'b1), .step_count(4)) uut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .ring_trip_raw_n(rt_n), .loop_closure_raw_n(lc_n),
    .power_alarm(alarm), .reverse_polarity(rev), .line_state_request(line_state_request),
    .off_hook(hook), .actual_line_state(state), .battery_switch_out(bsw),
    .feed_cfg(feed_cfg), .control_cfg(control_cfg), .use_low_battery(lowbat), .irq(irq));

  // external-battery twin shares the bus; only its feed side is looked at
  line_feed_regs #(.converter_variant(1'b0), .step_count(4)) uut_ext (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata_x), .ring_trip_raw_n(rt_n), .loop_closure_raw_n(lc_n),
    .power_alarm(alarm), .reverse_polarity(rev), .line_state_request(line_state_request),
    .off_hook(hook), .actual_line_state(), .battery_switch_out(bsw_x), .feed_cfg(),
    .control_cfg(), .use_low_battery(), .irq());

  // ****************
  // tasks
  // ****************
  function automatic logic [7:0] exp_feed(input logic conv, input logic [7:0] d);
    return conv ? (d & 8'h19) : ((d & 8'h02) | 8'h04);
  endfunction : exp_feed

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    rd_c = rdata;
    rd_x = rdata_x;
  endtask : rd

  task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 60; i++) begin
      rd(8'h44);
      if ((rd_c & m) === v) break;
    end
    chk(rd_c & m, v);
  endtask : wait_stat

  task automatic see_state(input logic [2:0] e);
    for (int i = 0; i < 20 && state !== e; i++) @(posedge ref_clk);
    #1;
    chk({5'h0, state}, {5'h0, e});
  endtask : see_state

  task automatic set_req(input logic [2:0] s);
    @(posedge ref_clk);
    line_state_request <= s;
    see_state(s);
  endtask : set_req

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // a hang is cut short well past the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      $display("BAD t=%0t timeout cycles=%h limit=%h", $time, cycles, 20000);
      close_out();
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    void'($urandom(48));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h42);
    chk(rd_c, 8'h03);
    chk(rd_x, 8'h06);
    chk({7'h0, bsw_x}, 8'h01);
    rd(8'h44);
    chk(rd_c, 8'h04);
    rd(8'h47);
    chk(rd_c, 8'h0a);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      wr(8'h42, w);
      rd(8'h42);
      chk(rd_c, exp_feed(1'b1, w));
      chk(rd_x, exp_feed(1'b0, w));
      chk({4'h0, feed_cfg}, {4'h0, w[4], w[3], 1'b0, w[0]});
      chk({6'h0, bsw, bsw_x}, {7'h0, w[1]});
      wr(8'h43, w);
      wr(8'h44, w);
      rd(8'h43);
      chk(rd_c, w & 8'h7f);
      chk({1'b0, control_cfg}, w & 8'h7f);
      chk({7'h0, lowbat}, 8'h00);
      rd(8'h44);
      chk(rd_c, 8'h04);
      rd(8'h60);
      chk(rd_c, 8'h00);
    end
    $display("test fields done");
    wr(8'h46, 8'h01);
    wr(8'h47, 8'h03);
    wr(8'h48, 8'h01);
    wr(8'h43, 8'h0a);
    set_req(3'h2);
    @(posedge ref_clk);
    want_loop <= 1'b1;
    // three steps of debounce: the flag must still be low a few cycles in
    repeat (4) @(posedge ref_clk);
    rd(8'h44);
    chk(rd_c, 8'h00);
    wait_stat(8'h07, 8'h01);
    see_state(3'h1);
    chk({6'h0, lowbat, irq}, 8'h03);
    wr(8'h45, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h0, irq}, 8'h00);
    @(posedge ref_clk);
    want_loop <= 1'b0;
    wait_stat(8'h07, 8'h04);
    $display("test loop closure done");
    wr(8'h46, 8'h00);
    wr(8'h43, 8'h04);
    // the request must move to be applied, so leave the active code behind
    set_req(3'h6);
    @(posedge ref_clk);
    want_rev  <= 1'b1;
    want_ring <= 1'b1;
    wait_stat(8'h07, 8'h02);
    see_state(3'h5);
    chk({7'h0, irq}, 8'h00);
    rd(8'h45);
    chk(rd_c & 8'h02, 8'h02);
    @(posedge ref_clk);
    want_ring <= 1'b0;
    want_rev  <= 1'b0;
    wait_stat(8'h07, 8'h04);
    $display("test ring trip done");
    wr(8'h43, 8'h01);
    set_req(3'h2);
    @(posedge ref_clk);
    want_alarm <= 1'b1;
    see_state(3'h0);
    @(posedge ref_clk);
    want_alarm <= 1'b0;
    $display("test power alarm done");
    wr(8'h43, 8'h00);
    set_req(3'h6);
    @(posedge ref_clk);
    want_loop  <= 1'b1;
    want_alarm <= 1'b1;
    wait_stat(8'h07, 8'h01);
    repeat (6) @(posedge ref_clk);
    #1;
    chk({5'h0, state}, 8'h06);
    $display("test manual mode done");
    close_out();
  end
endmodule : test_line_feed_regs
`default_nettype wire
